/* File: rtl/tpm_consts.svh */
/*
 * Constants of the timer PWM mode-select block: register offsets, field
 * positions and reset values. Assumes inclusion by all three design files.
 */
// Behaviour
// - Channel mode register clears to zero on power-on reset and either standby.
// - Mode register bits 7 to 3 always read zero; software writes zero.
// - Mode bits 2,1,0 put channels 5,4,3 in PWM mode; zero means capture/compare.
// - PWM channel drives pins A-C, register D is cycle, A-C are duties.
// - PWM channel ignores its two I/O control registers; A-D stay writable.
// - Sub-channel polarity/counting register clears on power-on reset and standby.
// - Polarity bits 7..4 select on-duty (zero) or off-duty (one) for D..A.
// - Counting bits 3..0 select non-complementary (zero) or complementary for D..A.
// - All eight polarity/counting bits are readable and writable.
`ifndef TPM_CONSTS_SVH
`define TPM_CONSTS_SVH

`define TPM_ADDR_W        12
`define TPM_OFS_MODE      12'h000
`define TPM_OFS_POLCNT    12'h004
`define TPM_OFS_STATUS    12'h008
`define TPM_OFS_CH_BASE   12'h010
`define TPM_CH_STRIDE     12'h020
`define TPM_CH_OFS_IOA    12'h010
`define TPM_CH_OFS_IOB    12'h014
`define TPM_CH_OFS_CNT    12'h018
`define TPM_MODE_MASK     8'h07
`define TPM_MODE_RESET    8'h00
`define TPM_POLCNT_RESET  8'h00
`define TPM_POL_LSB       4
`define TPM_CNT_LSB       0
`define TPM_NCH           3
`define TPM_NGR           4
`define TPM_CYCLE_IDX     3
`define TPM_GR_W          16
`define TPM_IO_HI_LSB     4

`endif

/* File: rtl/tpm_pkg.sv */
/*
 * Types of the timer PWM mode-select block.
 * Assumes the constants header is on the include path.
 */
`include "tpm_consts.svh"

package tpm_pkg;

	typedef logic [`TPM_GR_W-1:0] tpm_word_type;
	typedef tpm_word_type [`TPM_NGR-1:0] tpm_gr_set_type;

	// Compare action of one pin in capture/compare mode
	typedef enum logic [1:0]
	{
		TPM_ACT_OFF    = 2'h0,
		TPM_ACT_LOW    = 2'h1,
		TPM_ACT_HIGH   = 2'h2,
		TPM_ACT_TOGGLE = 2'h3
	} tpm_act_type;

	typedef struct packed
	{
		tpm_word_type              cnt_r;
		logic [`TPM_NGR-1:0]       pin_o_r;
		logic [`TPM_NGR-1:0]       pin_oe_r;
	} tpm_chan_state_type;

	typedef struct packed
	{
		logic [2:0]                hw_sync_r;
		logic                      hw_standby_r;
		logic                      dph_write_r;
		logic [`TPM_ADDR_W-1:0]    dph_addr_r;
		logic [7:0]                mode_r;
		logic [7:0]                polcnt_r;
		tpm_gr_set_type [`TPM_NCH-1:0] gr_r;
		logic [`TPM_NCH-1:0][7:0]  ioa_r;
		logic [`TPM_NCH-1:0][7:0]  iob_r;
		logic [31:0]               hrdata_r;
		logic                      hreadyout_r;
		logic [3:0]                sub_out_r;
		logic [3:0]                sub_comp_r;
	} tpm_top_state_type;

endpackage : tpm_pkg

/* File: rtl/tpm_chan.sv */
/*
 * One four-register timer channel: free-running counter with output compare,
 * or PWM with register D as cycle and A-C as duty.
 * Assumes registers and mode come from the register block on the same clock.
 */
`timescale 1ns/10ps
`include "tpm_consts.svh"

module tpm_chan
	import tpm_pkg::*;
(
	input  wire logic                hclk,
	input  wire logic                hresetn,
	input  wire logic                clear,
	input  wire logic                pwm_en,
	input  wire tpm_gr_set_type      gr,
	input  wire logic [7:0]          io_ctrl_a,
	input  wire logic [7:0]          io_ctrl_b,
	output logic [`TPM_NGR-1:0]      pin_o,
	output logic [`TPM_NGR-1:0]      pin_oe,
	output tpm_word_type             cnt
);

	tpm_chan_state_type s_r;
	tpm_chan_state_type s_nxt;

	// Pick the two-bit compare action of pin k
	function automatic tpm_act_type act_of(input logic [7:0] a, input logic [7:0] b,
		input int k);
		logic [7:0] sel;
		sel = (k < 2) ? a : b;
		act_of = tpm_act_type'((k % 2 == 0) ? sel[1:0] : sel[`TPM_IO_HI_LSB+1:`TPM_IO_HI_LSB]);
	endfunction : act_of

	// Counting and pin update
	always_comb
	begin
		s_nxt = s_r;
		if (clear)
		begin
			s_nxt = '0;
		end
		else if (pwm_en)
		begin
			// Pins A-C are PWM outputs; pin D is never driven here
			s_nxt.pin_oe_r = 4'h7;
			if (s_r.cnt_r == gr[`TPM_CYCLE_IDX])
			begin
				s_nxt.cnt_r   = '0;
				s_nxt.pin_o_r = 4'h7;
			end
			else
			begin
				s_nxt.cnt_r = s_r.cnt_r + 16'h0001;
				for (int k = 0; k < `TPM_CYCLE_IDX; k++)
				begin
					if (s_r.cnt_r == gr[k])
						s_nxt.pin_o_r[k] = 1'b0;
				end
			end
			s_nxt.pin_o_r[`TPM_CYCLE_IDX] = 1'b0;
		end
		else
		begin
			// Capture/compare mode: control registers steer each pin
			s_nxt.cnt_r = s_r.cnt_r + 16'h0001;
			for (int k = 0; k < `TPM_NGR; k++)
			begin
				s_nxt.pin_oe_r[k] = (act_of(io_ctrl_a, io_ctrl_b, k) != TPM_ACT_OFF);
				if (s_r.cnt_r == gr[k])
				begin
					unique case (act_of(io_ctrl_a, io_ctrl_b, k))
						TPM_ACT_OFF:    s_nxt.pin_o_r[k] = s_r.pin_o_r[k];
						TPM_ACT_LOW:    s_nxt.pin_o_r[k] = 1'b0;
						TPM_ACT_HIGH:   s_nxt.pin_o_r[k] = 1'b1;
						TPM_ACT_TOGGLE: s_nxt.pin_o_r[k] = ~s_r.pin_o_r[k];
					endcase
				end
			end
		end
	end

	// State register
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			s_r <= '0;
		else
			s_r <= s_nxt;
	end

	assign pin_o  = s_r.pin_o_r;
	assign pin_oe = s_r.pin_oe_r;
	assign cnt    = s_r.cnt_r;

endmodule : tpm_chan

/* File: rtl/tpm_top.sv */
/*
 * Timer PWM mode select: AHB-Lite register slave holding the channel mode
 * register, the sub-channel polarity/counting register and the general and
 * I/O control registers of channels 3 to 5, which it runs as tpm_chan blocks.
 * Assumes a single AHB-Lite master, hclk at 100 MHz, sw_standby from logic
 * on hclk and hw_standby straight from a pin.
 */
// The placing of the registers and the AHB-Lite slave port are this design's own decisions.
`timescale 1ns/10ps
`include "tpm_consts.svh"

module tpm_top
	import tpm_pkg::*;
(
	input  wire logic                     hclk,
	input  wire logic                     hresetn,
	input  wire logic                     hsel,
	input  wire logic [31:0]              haddr,
	input  wire logic [1:0]               htrans,
	input  wire logic                     hwrite,
	input  wire logic [2:0]               hsize,
	input  wire logic [31:0]              hwdata,
	input  wire logic                     hready,
	output logic [31:0]                   hrdata,
	output logic                          hreadyout,
	output logic                          hresp,
	input  wire logic                     hw_standby,
	input  wire logic                     sw_standby,
	input  wire logic [3:0]               sub_duty_raw,
	output logic [3:0]                    sub_output,
	output logic [3:0]                    sub_comp_mode,
	output logic [`TPM_NCH-1:0][3:0]      ch_pin_o,
	output logic [`TPM_NCH-1:0][3:0]      ch_pin_oe
);

	tpm_top_state_type s_r;
	tpm_top_state_type s_nxt;

	logic                    clear;
	logic [`TPM_NCH-1:0]     pwm_en;
	tpm_word_type [`TPM_NCH-1:0] ch_cnt;

	// Channel index of an address, or TPM_NCH when outside all channel windows
	function automatic int chan_of(input logic [`TPM_ADDR_W-1:0] a);
		chan_of = `TPM_NCH;
		for (int c = 0; c < `TPM_NCH; c++)
		begin
			if (a >= `TPM_OFS_CH_BASE + `TPM_ADDR_W'(c) * `TPM_CH_STRIDE &&
				a <  `TPM_OFS_CH_BASE + `TPM_ADDR_W'(c + 1) * `TPM_CH_STRIDE)
				chan_of = c;
		end
	endfunction : chan_of

	// Offset of an address within its channel window
	function automatic logic [`TPM_ADDR_W-1:0] chan_ofs(input logic [`TPM_ADDR_W-1:0] a);
		chan_ofs = (a - `TPM_OFS_CH_BASE) & (`TPM_CH_STRIDE - `TPM_ADDR_W'(1));
	endfunction : chan_ofs

	// Read value of an address from a given state copy; unmapped reads zero
	function automatic logic [31:0] read_of(input tpm_top_state_type s,
		input logic [`TPM_ADDR_W-1:0] a, input tpm_word_type [`TPM_NCH-1:0] cnts);
		int c;
		logic [`TPM_ADDR_W-1:0] o;
		read_of = 32'h0000_0000;
		c = chan_of(a);
		o = chan_ofs(a);
		if (a == `TPM_OFS_MODE)
			read_of = {24'h00_0000, s.mode_r & `TPM_MODE_MASK};
		else if (a == `TPM_OFS_POLCNT)
			read_of = {24'h00_0000, s.polcnt_r};
		else if (a == `TPM_OFS_STATUS)
			read_of = {28'h000_0000, s.sub_out_r};
		else if (c < `TPM_NCH)
		begin
			if (o < `TPM_CH_OFS_IOA)
				read_of = {16'h0000, s.gr_r[c][o[3:2]]};
			else if (o == `TPM_CH_OFS_IOA)
				read_of = {24'h00_0000, s.ioa_r[c]};
			else if (o == `TPM_CH_OFS_IOB)
				read_of = {24'h00_0000, s.iob_r[c]};
			else if (o == `TPM_CH_OFS_CNT)
				read_of = {16'h0000, cnts[c]};
		end
	endfunction : read_of

	// Bus, standby filter and register updates
	always_comb
	begin
		int c;
		logic [`TPM_ADDR_W-1:0] o;
		logic [`TPM_ADDR_W-1:0] a;
		c = chan_of(s_r.dph_addr_r);
		o = chan_ofs(s_r.dph_addr_r);
		a = s_r.dph_addr_r;
		s_nxt = s_r;
		s_nxt.hreadyout_r = 1'b1;

		// Pin standby passes three flops; the filtered level moves once 2nd and 3rd agree
		s_nxt.hw_sync_r = {s_r.hw_sync_r[1:0], hw_standby};
		if (s_r.hw_sync_r[1] == s_r.hw_sync_r[2])
			s_nxt.hw_standby_r = s_r.hw_sync_r[2];

		// Data phase of a write lands here; zero wait states
		if (s_r.dph_write_r)
		begin
			if (a == `TPM_OFS_MODE)
				s_nxt.mode_r = hwdata[7:0] & `TPM_MODE_MASK;
			else if (a == `TPM_OFS_POLCNT)
				s_nxt.polcnt_r = hwdata[7:0];
			else if (c < `TPM_NCH)
			begin
				// General registers stay writable whatever the channel mode
				if (o < `TPM_CH_OFS_IOA)
					s_nxt.gr_r[c][o[3:2]] = hwdata[`TPM_GR_W-1:0];
				else if (o == `TPM_CH_OFS_IOA)
					s_nxt.ioa_r[c] = hwdata[7:0];
				else if (o == `TPM_CH_OFS_IOB)
					s_nxt.iob_r[c] = hwdata[7:0];
			end
		end

		// Standby wipes both mode registers; later writes are lost while it lasts
		if (s_r.hw_standby_r || sw_standby)
		begin
			s_nxt.mode_r   = `TPM_MODE_RESET;
			s_nxt.polcnt_r = `TPM_POLCNT_RESET;
		end

		// Address phase capture; only full-word transfers are defined
		s_nxt.dph_write_r = 1'b0;
		if (hready)
		begin
			s_nxt.dph_addr_r = haddr[`TPM_ADDR_W-1:0];
			s_nxt.dph_write_r = hsel && htrans[1] && hwrite;
			// Read data taken from the post-write copy so back-to-back access sees it
			if (hsel && htrans[1] && !hwrite)
				s_nxt.hrdata_r = read_of(s_nxt, haddr[`TPM_ADDR_W-1:0], ch_cnt);
			else
				s_nxt.hrdata_r = 32'h0000_0000;
		end

		// Sub-channel polarity: a one inverts to off-duty
		s_nxt.sub_out_r  = sub_duty_raw ^ s_r.polcnt_r[`TPM_POL_LSB+3:`TPM_POL_LSB];
		s_nxt.sub_comp_r = s_r.polcnt_r[`TPM_CNT_LSB+3:`TPM_CNT_LSB];
	end

	// State register
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			s_r <= '0;
		end
		else
		begin
			s_r <= s_nxt;
		end
	end

	assign clear  = s_r.hw_standby_r | sw_standby;
	assign pwm_en = s_r.mode_r[`TPM_NCH-1:0];

	// Channels 3, 4, 5 in bit order 0, 1, 2; PWM mode hides I/O control settings
	generate
		for (genvar g = 0; g < `TPM_NCH; g++)
		begin : g_chan
			tpm_chan u_chan
			(
				.hclk      (hclk),
				.hresetn   (hresetn),
				.clear     (clear),
				.pwm_en    (pwm_en[g]),
				.gr        (s_r.gr_r[g]),
				.io_ctrl_a (pwm_en[g] ? 8'h00 : s_r.ioa_r[g]),
				.io_ctrl_b (pwm_en[g] ? 8'h00 : s_r.iob_r[g]),
				.pin_o     (ch_pin_o[g]),
				.pin_oe    (ch_pin_oe[g]),
				.cnt       (ch_cnt[g])
			);
		end
	endgenerate

	assign hrdata        = s_r.hrdata_r;
	assign hreadyout     = s_r.hreadyout_r;
	assign hresp         = 1'b0;
	assign sub_output    = s_r.sub_out_r;
	assign sub_comp_mode = s_r.sub_comp_r;

endmodule : tpm_top

/* File: testbench/tpm_top_chk.sv */
/*
 * Checker for tpm_top: bus answers, sub-channel outputs and PWM pin enables.
 * Assumes one master on the bus; transfers are qualified by the bus hready.
 */
`timescale 1ns/10ps
`include "tpm_consts.svh"

module tpm_top_chk
	import tpm_pkg::*;
(
	input wire logic                hclk,
	input wire logic                hresetn,
	input wire logic                hsel,
	input wire logic [31:0]         haddr,
	input wire logic [1:0]          htrans,
	input wire logic                hwrite,
	input wire logic [31:0]         hwdata,
	input wire logic                hready,
	input wire logic [31:0]         hrdata,
	input wire logic                hreadyout,
	input wire logic                hresp,
	input wire logic                hw_standby,
	input wire logic                sw_standby,
	input wire logic [3:0]          sub_duty_raw,
	input wire logic [3:0]          sub_output,
	input wire logic [3:0]          sub_comp_mode,
	input wire logic [`TPM_NCH-1:0][3:0] ch_pin_oe
);
	logic        dw_r, dr_r;
	logic [11:0] da_r;
	logic [2:0]  mode_r, mdd_r;
	logic [7:0]  pol_r;
	logic [3:0]  exp_r, cmp_r;
	logic [4:0]  hs_r;
	// Pin standby is filtered late in the design, so the shadow clears early and long
	wire logic clr = sw_standby | hw_standby | (|hs_r);
	wire logic qt  = !hw_standby && hs_r == 5'h00;

	// Shadow copies of the two select registers
	always_ff @(posedge hclk or negedge hresetn)
		if (!hresetn)
			{dw_r, dr_r, da_r, mode_r, mdd_r, pol_r, exp_r, cmp_r, hs_r} <= '0;
		else
		begin
			hs_r <= {hs_r[3:0], hw_standby};
			dw_r <= hready && hsel && htrans[1] && hwrite;
			dr_r <= hready && hsel && htrans[1] && !hwrite;
			da_r <= haddr[11:0];
			mdd_r <= mode_r;
			exp_r <= sub_duty_raw ^ pol_r[7:4];
			cmp_r <= pol_r[3:0];
			if (clr)
				{mode_r, pol_r} <= '0;
			else if (dw_r && da_r == `TPM_OFS_MODE)
				mode_r <= hwdata[2:0];
			else if (dw_r && da_r == `TPM_OFS_POLCNT)
				pol_r <= hwdata[7:0];
		end

	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);

	resp_okay_a: assert property (hresp == 1'b0) else $error("response not okay");
	ready_up_a: assert property ($past(hresetn) |-> hreadyout) else $error("wait state seen");
	rdata_idle_a: assert property (!dr_r |-> hrdata == 32'h0) else $error("stray read data");
	rd_mode_a: assert property (dr_r && da_r == `TPM_OFS_MODE |-> hrdata == {29'h0, mode_r})
		else $error("mode read wrong");
	rd_pol_a: assert property (dr_r && da_r == `TPM_OFS_POLCNT |-> hrdata == {24'h0, pol_r})
		else $error("polarity read wrong");
	sub_out_a: assert property ($past(hresetn) && $past(qt) |-> sub_output == exp_r)
		else $error("sub output polarity wrong");
	sub_comp_a: assert property ($past(hresetn) && $past(qt) |-> sub_comp_mode == cmp_r)
		else $error("counting mode wrong");
	pwm3_oe_a: assert property (mdd_r[0] && mode_r[0] |-> ch_pin_oe[0] == 4'h7)
		else $error("ch3 pwm enables wrong");
	pwm4_oe_a: assert property (mdd_r[1] && mode_r[1] |-> ch_pin_oe[1] == 4'h7)
		else $error("ch4 pwm enables wrong");
	pwm5_oe_a: assert property (mdd_r[2] && mode_r[2] |-> ch_pin_oe[2] == 4'h7)
		else $error("ch5 pwm enables wrong");
endmodule : tpm_top_chk

bind tpm_top tpm_top_chk chk_u (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hwdata,
	.hready, .hrdata, .hreadyout, .hresp, .hw_standby, .sw_standby, .sub_duty_raw, .sub_output,
	.sub_comp_mode, .ch_pin_oe);

/* File: testbench/tpm_load.sv */
/*
 * Loads on the timer pins: counts high cycles of pins A to C of each channel.
 * Assumes pull-downs on every pin, so a released pin reads low.
 */
`timescale 1ns/10ps
`include "tpm_consts.svh"

module tpm_load
(
	input wire logic                     hclk,
	input wire logic [`TPM_NCH-1:0][3:0] pin_o,
	input wire logic [`TPM_NCH-1:0][3:0] pin_oe,
	output int                           hi_pin [`TPM_NCH][3]
);
	logic [`TPM_NCH-1:0][3:0] lvl;
	// Wire level with pull-downs; pin D is never loaded, a PWM channel may not use it
	assign lvl = pin_o & pin_oe;
	initial foreach (hi_pin[c, k]) hi_pin[c][k] = 0;
	// Duty meters on pins A to C, the PWM outputs
	always @(posedge hclk)
		for (int c = 0; c < `TPM_NCH; c++)
			for (int k = 0; k < 3; k++)
				if (lvl[c][k] === 1'b1)
					hi_pin[c][k] <= hi_pin[c][k] + 1;
endmodule : tpm_load

/* File: testbench/tpm_top_tb_top.sv */
/*
 * Testbench for tpm_top: AHB-Lite master tasks and one task per scenario.
 * Assumes the checker is bound and tpm_load sits on the channel pins.
 */
`timescale 1ns/10ps
`include "tpm_consts.svh"

module tpm_top_tb_top
	import tpm_pkg::*;
;
	logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
	logic        hw_standby = 1'b0, sw_standby = 1'b0, hreadyout, hresp;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, q;
	logic [1:0]  htrans = 2'h0;
	logic [3:0]  sub_duty_raw = 4'h0, sub_output, sub_comp_mode;
	logic [`TPM_NCH-1:0][3:0] ch_pin_o, ch_pin_oe;
	int          hi_pin [`TPM_NCH][3];
	int          bad_count = 0, n_compared = 0;

	// 100 MHz clock
	always #5 hclk = ~hclk;

	tpm_top dut_u (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
		.hready(hreadyout), .hrdata, .hreadyout, .hresp, .hw_standby, .sw_standby,
		.sub_duty_raw, .sub_output, .sub_comp_mode, .ch_pin_o, .ch_pin_oe);
	tpm_load load_u (.hclk, .pin_o(ch_pin_o), .pin_oe(ch_pin_oe), .hi_pin);

	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_compared++;
		if (g !== e)
		begin
			bad_count++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	// Waits for hready high at a rising edge; read data is taken at that same edge
	task wait_rdy;
		do
			@(posedge hclk);
		while (hreadyout !== 1'b1);
		q = hrdata;
	endtask : wait_rdy

	task ahb(input logic w, input logic [11:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		haddr <= {20'h0, a};
		htrans <= 2'h2;
		hwrite <= w;
		wait_rdy;
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		wait_rdy;
	endtask : ahb

	task results;
		$display("compared %0d mismatches %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : results

	task t_reset;
		ahb(1'b0, `TPM_OFS_MODE, 32'h0);
		chk("mode reset", 32'h0, q);
		ahb(1'b0, `TPM_OFS_POLCNT, 32'h0);
		chk("polcnt reset", 32'h0, q);
		ahb(1'b0, 12'h0fc, 32'h0);
		chk("unmapped read", 32'h0, q);
		ahb(1'b1, `TPM_OFS_MODE, 32'hff);
		ahb(1'b0, `TPM_OFS_MODE, 32'h0);
		chk("mode spare bits", 32'h7, q);
	endtask : t_reset

	// Each select bit alone, raw levels alternating so every bit flips an output
	task t_pol;
		logic [7:0] p;
		for (int i = 0; i < 8; i++)
		begin
			p = 8'h01 << i;
			ahb(1'b1, `TPM_OFS_POLCNT, {24'h0, p});
			ahb(1'b0, `TPM_OFS_POLCNT, 32'h0);
			chk("polcnt rw", {24'h0, p}, q);
			sub_duty_raw <= i[0] ? 4'ha : 4'h5;
			repeat (2) @(negedge hclk);
			chk("sub output", {28'h0, sub_duty_raw ^ p[7:4]}, {28'h0, sub_output});
			chk("count mode", {28'h0, p[3:0]}, {28'h0, sub_comp_mode});
			@(posedge hclk);
		end
	endtask : t_pol

	// Period 10 with duties 2, 4, 6 gives 3, 5 and 7 high cycles in every ten
	task t_pwm(input int c);
		logic [11:0] b;
		int          h0 [3];
		b = 12'h010 + 12'h020 * c[11:0];
		ahb(1'b1, b, 32'h2);
		ahb(1'b1, b + 12'h004, 32'h4);
		ahb(1'b1, b + 12'h008, 32'h6);
		ahb(1'b1, b + 12'h00c, 32'h9);
		ahb(1'b1, b + 12'h010, 32'h33);
		sw_standby <= 1'b1;
		@(posedge hclk);
		sw_standby <= 1'b0;
		ahb(1'b1, `TPM_OFS_MODE, 32'h1 << c);
		repeat (12) @(negedge hclk);
		chk("pwm pin enables", 32'h7, {28'h0, ch_pin_oe[c]});
		h0 = hi_pin[c];
		repeat (50) @(negedge hclk);
		chk("pin a high cycles", 32'd15, hi_pin[c][0] - h0[0]);
		chk("pin b high cycles", 32'd25, hi_pin[c][1] - h0[1]);
		chk("pin c high cycles", 32'd35, hi_pin[c][2] - h0[2]);
		ahb(1'b0, b + 12'h00c, 32'h0);
		chk("cycle reg", 32'h9, q);
		ahb(1'b1, `TPM_OFS_MODE, 32'h0);
	endtask : t_pwm

	task t_standby;
		ahb(1'b1, `TPM_OFS_MODE, 32'h7);
		ahb(1'b1, `TPM_OFS_POLCNT, 32'hff);
		sw_standby <= 1'b1;
		@(posedge hclk);
		sw_standby <= 1'b0;
		ahb(1'b0, `TPM_OFS_MODE, 32'h0);
		chk("mode after sw standby", 32'h0, q);
		ahb(1'b0, `TPM_OFS_POLCNT, 32'h0);
		chk("polcnt after sw standby", 32'h0, q);
		ahb(1'b1, `TPM_OFS_MODE, 32'h5);
		ahb(1'b1, `TPM_OFS_POLCNT, 32'h5a);
		hw_standby <= 1'b1;
		repeat (6) @(posedge hclk);
		hw_standby <= 1'b0;
		repeat (8) @(posedge hclk);
		ahb(1'b0, `TPM_OFS_MODE, 32'h0);
		chk("mode after hw standby", 32'h0, q);
		ahb(1'b0, `TPM_OFS_POLCNT, 32'h0);
		chk("polcnt after hw standby", 32'h0, q);
	endtask : t_standby

	// Main sequence after 16 cycles of reset
	initial
	begin
		repeat (16) @(posedge hclk);
		hresetn <= 1'b1;
		t_reset;
		t_pol;
		for (int c = 0; c < `TPM_NCH; c++)
			t_pwm(c);
		t_standby;
		results;
	end

	// Watchdog: the run needs about 350 cycles
	initial
	begin
		#100000;
		bad_count++;
		results;
	end
endmodule : tpm_top_tb_top
